/* bench/iox_pin_model.sv */
// Board model around the open-drain ports: external drivers and internal pullups.
`timescale 1ns/100ps
module iox_pin_model (
    input  wire logic       core_clk,
    input  wire logic [3:0] odOut,
    input  wire logic [3:0] odOe,
    input  wire logic [3:0] pullupEn,
    input  wire logic [3:0] extEn,
    input  wire logic [3:0] extVal,
    output logic      [3:0] odLevel
);
    logic [3:0] floatPat = 4'h5;

    // A port nobody drives wanders every cycle, so it never passes for a held level.
    always @(posedge core_clk) begin
        floatPat <= ~floatPat;
    end

    // Each wire: the device pull-down wins, then the outside driver, then the pullup.
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (odOe[i]) begin
                odLevel[i] = odOut[i];
            end else if (extEn[i]) begin
                odLevel[i] = extVal[i];
            end else if (pullupEn[i]) begin
                odLevel[i] = 1'b1;
            end else begin
                odLevel[i] = floatPat[i];
            end
        end
    end
endmodule : iox_pin_model

/* bench/tb.sv */
// Self-checking bench for the port core: defaults, readback, change flags, clear, standby.
`timescale 1ns/100ps
module tb import iox_pkg::*;;
    logic       core_clk;
    logic       arst_n;
    logic       clr_n;
    logic [1:0] addrSelLo;
    logic [1:0] addrSelHi;
    logic [3:0] busAddr;
    logic [7:0] busWrData;
    logic       busWr;
    logic       busRd;
    logic [7:0] busRdData;
    logic [7:0] upperOut;
    logic [3:0] lowerOut;
    logic [3:0] odIn;
    logic [3:0] odOut;
    logic [3:0] odOe;
    logic [3:0] pullupEn;
    logic       intReqOut;
    logic       intReqOe;
    logic       standby;
    logic [3:0] extEn;
    logic [3:0] extVal;
    logic [7:0] rdQ[$];
    logic       rdSeen;
    int         miscompares;
    int         n_tests;
    int         cycles;

    iox_port_core DUT (.core_clk, .arst_n, .clr_n, .addrSelLo, .addrSelHi, .busAddr,
        .busWrData, .busWr, .busRd, .busRdData, .upperOut, .lowerOut, .odIn, .odOut,
        .odOe, .pullupEn, .intReqOut, .intReqOe, .standby);

    iox_pin_model pins (.core_clk, .odOut, .odOe, .pullupEn, .extEn, .extVal,
        .odLevel(odIn));

    // Free-running 100 MHz clock.
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_sim

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check

    // One bus cycle; the strobes stay as set until the next call changes them.
    task automatic op(input logic w, input logic r, input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        busWr     <= w;
        busRd     <= r;
        busAddr   <= a;
        busWrData <= d;
    endtask : op

    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        rdQ.push_back(exp);
        op(1'b0, 1'b1, a, 8'h00);
    endtask : rd

    task automatic rst(input logic [1:0] lo, input logic [1:0] hi);
        @(posedge core_clk);
        arst_n    <= 1'b0;
        addrSelLo <= lo;
        addrSelHi <= hi;
        busWr     <= 1'b0;
        busRd     <= 1'b0;
        repeat (2) @(posedge core_clk);
        check(upperOut, 8'h00);
        arst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
    endtask : rst

    // Brief pulse on one input port, then wait out the flag and interrupt latency.
    task automatic pulse(input int k);
        @(posedge core_clk);
        extVal[k] <= ~extVal[k];
        @(posedge core_clk);
        extVal[k] <= ~extVal[k];
        repeat (4) @(posedge core_clk);
        #1;
    endtask : pulse

    // Read data stand one cycle after the strobe; compare with the oldest note.
    always @(posedge core_clk) begin
        if (rdSeen) begin
            check(busRdData, rdQ.pop_front());
        end
        rdSeen <= busRd;
    end

    // Hang guard.
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            end_sim();
        end
    end

    initial begin
        logic [7:0] d;
        logic [7:0] e;
        logic [1:0] lo;
        logic [1:0] hi;
        logic       l;
        logic       h;
        void'($urandom(40688));
        {arst_n, clr_n, busWr, busRd, rdSeen} = 5'b01000;
        {addrSelLo, addrSelHi, busAddr, busWrData} = 16'hF000;
        extEn  = 4'hF;
        extVal = 4'($urandom);
        rst(2'h3, 2'h3);
        d = 8'($urandom);
        e = 8'($urandom) | 8'h3C;
        op(1'b1, 1'b0, OFS_UPPER, d);
        op(1'b1, 1'b0, OFS_LOWER, e);
        op(1'b0, 1'b0, 4'h0, 8'h00);
        #1;
        check(8'(standby), 8'h00);
        op(1'b1, 1'b0, OFS_FLAGS, 8'hFF);
        op(1'b1, 1'b0, 4'hC, ~d);
        rd(OFS_UPPER, d);
        rd(OFS_LOWER, {e[7:6], extVal, e[1:0]});
        rd(OFS_FLAGS, 8'h00);
        rd(4'hC, 8'h00);
        op(1'b0, 1'b0, 4'h0, 8'h00);
        repeat (2) @(posedge core_clk);
        #1;
        check(8'(standby), 8'h01);
        check(8'(lowerOut), {4'h0, e[7:6], e[1:0]});
        $display("Test readback done");
        for (int k = 0; k < 4; k++) begin
            pulse(k);
            check(8'(intReqOe), 8'h01);
            check(8'(intReqOut), 8'h00);
            if (k[0]) begin
                op(1'b1, 1'b0, OFS_UPPER, d);
                rd(OFS_FLAGS, 8'h00);
            end else begin
                rd(OFS_FLAGS, 8'(1 << k));
            end
            op(1'b0, 1'b0, 4'h0, 8'h00);
            repeat (2) @(posedge core_clk);
            #1;
            check(8'(intReqOe), 8'h00);
        end
        $display("Test change detection done");
        pulse(0);
        @(posedge core_clk);
        clr_n <= 1'b0;
        op(1'b1, 1'b0, OFS_UPPER, ~d);
        rd(OFS_FLAGS, 8'h00);
        op(1'b0, 1'b0, 4'h0, 8'h00);
        #1;
        check(8'(standby), 8'h01);
        @(posedge core_clk);
        clr_n <= 1'b1;
        #1;
        check(8'(intReqOe), 8'h01);
        check(upperOut, d);
        rd(OFS_FLAGS, 8'h01);
        op(1'b0, 1'b0, 4'h0, 8'h00);
        $display("Test external clear done");
        extEn <= 4'h0;
        for (int i = 0; i < 4; i++) begin
            lo = 2'(i);
            hi = 2'(i + 2);
            l  = lo != 2'h0;
            h  = hi != 2'h0;
            rst(lo, hi);
            #1;
            check(upperOut, {{4{h}}, {4{l}}});
            check(8'(lowerOut), {4'h0, h, h, l, l});
            check(8'(odOe), {4'h0, ~h, ~h, ~l, ~l});
            check(8'(odOut), 8'h00);
            check(8'(pullupEn), {4'h0, h, h, l, l});
            check(8'(intReqOe), 8'h00);
            rd(OFS_LOWER, {{4{h}}, {4{l}}});
            rd(OFS_FLAGS, 8'h00);
            op(1'b0, 1'b0, 4'h0, 8'h00);
            repeat (2) @(posedge core_clk);
        end
        $display("Test power-up defaults done");
        end_sim();
    end
endmodule : tb

/* core/iox_change_det.sv */
// Latching transition detector with change flags and interrupt request.
`timescale 1ns/100ps
module iox_change_det
    import iox_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic arst_n,
    iox_evt_if.det    evt
);
    logic [3:0] refLevel;
    logic [3:0] diff;
    logic [3:0] next_flags;
    logic       next_int;

    // Only ports whose latch is high act as inputs and may report a change.
    assign diff       = evt.armed ? ((evt.pinSample ^ refLevel) & evt.inputMask) : 4'h0;
    // An access clears flags, but a change seen in the same cycle still sets them.
    assign next_flags = evt.access ? diff : (evt.changeFlags | diff);
    assign next_int   = evt.access ? (|diff) : (evt.intReq | (|diff));

    // Reference follows the pins until armed, then only at each access.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            refLevel        <= 4'h0;
            evt.changeFlags <= 4'h0;
            evt.intReq      <= 1'b0;
        end else begin
            refLevel        <= (!evt.armed || evt.access) ? evt.pinSample : refLevel;
            evt.changeFlags <= next_flags;
            evt.intReq      <= next_int;
        end
    end

    a_flag_sets: assert property (@(posedge core_clk) disable iff (!arst_n)
        (diff != 4'h0) |=> ((evt.changeFlags & $past(diff)) == $past(diff)))
        else $error("Detected change did not set its flag.");

    a_access_clears: assert property (@(posedge core_clk) disable iff (!arst_n)
        (evt.access && diff == 4'h0) |=> (evt.changeFlags == 4'h0 && !evt.intReq))
        else $error("Access left a flag or request set.");

    a_int_latched: assert property (@(posedge core_clk) disable iff (!arst_n)
        (evt.intReq && !evt.access) |=> evt.intReq)
        else $error("Interrupt request dropped without an access.");
endmodule : iox_change_det

/* core/iox_evt_if.sv */
// Interface carrying samples, access events and change results between core and detector.
`timescale 1ns/100ps
interface iox_evt_if;
    logic [3:0] pinSample;
    logic [3:0] inputMask;
    logic       access;
    logic       armed;
    logic [3:0] changeFlags;
    logic       intReq;

    modport core (output pinSample, inputMask, access, armed, input changeFlags, intReq);
    modport det  (input pinSample, inputMask, access, armed, output changeFlags, intReq);
endinterface : iox_evt_if

/* core/iox_pkg.sv */
// Package with offsets, field positions, reset values and strap codes of the port core.
package iox_pkg;

    // Bus geometry.
    localparam int          IOX_DATA_W   = 8;
    localparam int          IOX_ADDR_W   = 4;
    localparam int          IOX_NUM_OD   = 4;
    localparam int          IOX_NUM_LOPP = 4;

    // Byte addresses of the register port.
    localparam logic [3:0]  OFS_UPPER    = 4'h0;
    localparam logic [3:0]  OFS_LOWER    = 4'h4;
    localparam logic [3:0]  OFS_FLAGS    = 4'h8;

    // Field positions inside the lower group byte: O0,O1 | OPEN_DRAIN_PORTS | O6,O7.
    localparam int          LOW_PPA_LSB  = 0;
    localparam int          LOW_OD_LSB   = 2;
    localparam int          LOW_PPB_LSB  = 6;

    // Values held while the power-on clear is active.
    localparam logic [7:0]  RST_UPPER    = 8'h00;
    localparam logic [3:0]  RST_LOPP     = 4'h0;
    localparam logic [3:0]  RST_OD       = 4'h0;
    localparam logic [7:0]  RST_RDATA    = 8'h00;

    // Decoded four-level address-select codes.
    localparam logic [1:0]  SEL_GND      = 2'h0;
    localparam logic [1:0]  SEL_VPLUS    = 2'h1;
    localparam logic [1:0]  SEL_SCL      = 2'h2;
    localparam logic [1:0]  SEL_SDA      = 2'h3;

    // A select input reads as high unless it is tied to ground.
    function automatic logic iox_sel_high(input logic [1:0] code);
        return code != SEL_GND;
    endfunction : iox_sel_high

endpackage : iox_pkg

/* core/iox_port_core.sv */
// Port logic of the sixteen-port expander: latches, readback, change detection, standby.
//
// Contract
// - Any change on an input open-drain port sets that port's change flag.
// - Every change flag clears on the next read or write access; a change still held at that access stays flagged until the following one.
// - Input data change pulls the interrupt request low and keeps it latched.
// - The next serial access releases the interrupt request; a change still held at that access keeps it set until the following one.
// - Open-drain pullups are enabled in pairs from the address selects.
// - Open-drain port with pullup enabled leaves reset with latch high.
// - Open-drain port with pullup disabled leaves reset with latch low.
// - Push-pull power-up levels follow the decoded address selects in pairs.
// - Power-up resets detection, clears flags and holds interrupt inactive.
// - Registers and interface stay in reset until power-on clear releases.
// - Supply falling below threshold returns all registers to defaults.
// - External clear aborts the transaction and forces the idle state.
// - External clear leaves the interrupt output and its latch unchanged.
// - Device enters standby automatically whenever the interface is idle.
// - Upper eight outputs and lower group answer at separate addresses.
// - Open-drain port reads return the actual pin levels; push-pull and upper reads return the latches.
// - Low select sets pullups of first two ports, high select last two.
// - High, clock or data tie enables pullups and high default; ground disables.
`timescale 1ns/100ps
module iox_port_core
    import iox_pkg::*;
#(
    parameter int ADDR_W = IOX_ADDR_W
)
(
    input  wire logic              core_clk,
    input  wire logic              arst_n,
    input  wire logic              clr_n,
    input  wire logic [1:0]        addrSelLo,
    input  wire logic [1:0]        addrSelHi,
    input  wire logic [ADDR_W-1:0] busAddr,
    input  wire logic [7:0]        busWrData,
    input  wire logic              busWr,
    input  wire logic              busRd,
    output logic      [7:0]        busRdData,
    output logic      [7:0]        upperOut,
    output logic      [3:0]        lowerOut,
    input  wire logic [3:0]        odIn,
    output logic      [3:0]        odOut,
    output logic      [3:0]        odOe,
    output logic      [3:0]        pullupEn,
    output logic                   intReqOut,
    output logic                   intReqOe,
    output logic                   standby
);
    typedef enum logic [1:0] {ST_LOAD, ST_IDLE, ST_BUSY} iox_state_t;

    iox_state_t state;
    iox_state_t next_state;

    iox_evt_if evt ();

    logic [3:0] odLatch;
    logic [3:0] pinSample;
    logic [7:0] defUpper;
    logic [3:0] defLoPp;
    logic [3:0] defOd;
    logic [3:0] pullupSel;

    logic       hitUpper;
    logic       hitLower;
    logic       hitFlags;
    logic       hitAny;
    logic       wrOk;
    logic       rdOk;
    logic       wrUpper;
    logic       wrLower;
    logic [7:0] lowerView;
    logic [7:0] next_rdData;
    logic [7:0] next_upper;
    logic [3:0] next_loPp;
    logic [3:0] next_od;

    // Two-stage arming delay for the change detector after the load.
    logic [1:0] armDly;

    // Strap decoder for defaults and pullup pairs.
    iox_sel_decode u_sel (
        .addrSelLo (addrSelLo),
        .addrSelHi (addrSelHi),
        .defUpper  (defUpper),
        .defLoPp   (defLoPp),
        .defOd     (defOd),
        .pullupSel (pullupSel)
    );

    // Transition detector with its flags and latched request.
    iox_change_det u_det (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .evt      (evt.core)
    );

    // Address decode; the upper group and the lower group sit at separate offsets.
    assign hitUpper = busAddr == ADDR_W'(OFS_UPPER);
    assign hitLower = busAddr == ADDR_W'(OFS_LOWER);
    assign hitFlags = busAddr == ADDR_W'(OFS_FLAGS);
    assign hitAny   = hitUpper | hitLower | hitFlags;

    // Strobes are ignored while the external clear is held or defaults are loading.
    assign wrOk     = busWr && clr_n && (state != ST_LOAD);
    assign rdOk     = busRd && clr_n && (state != ST_LOAD);
    assign wrUpper  = wrOk && hitUpper;
    assign wrLower  = wrOk && hitLower;

    // Lower group view: push-pull bits from their latches, open-drain bits from the pins.
    assign lowerView = {lowerOut[3:2], pinSample, lowerOut[1:0]};

    // Read mux; an unmapped address reads as zero.
    assign next_rdData = !rdOk    ? RST_RDATA :
                         hitUpper ? upperOut :
                         hitLower ? lowerView :
                         hitFlags ? {4'h0, evt.changeFlags} : RST_RDATA;

    // Latch updates; straps set the defaults in the first cycle after power-on clear.
    assign next_upper = (state == ST_LOAD) ? defUpper : (wrUpper ? busWrData : upperOut);
    assign next_loPp  = (state == ST_LOAD) ? defLoPp :
                        (wrLower ? {busWrData[LOW_PPB_LSB +: 2], busWrData[LOW_PPA_LSB +: 2]}
                                 : lowerOut);
    assign next_od    = (state == ST_LOAD) ? defOd :
                        (wrLower ? busWrData[LOW_OD_LSB +: IOX_NUM_OD] : odLatch);

    // Detector hookup; any mapped access that is taken counts as a transaction.
    assign evt.pinSample = pinSample;
    assign evt.inputMask = odLatch;
    assign evt.access    = (wrOk || rdOk) && hitAny;
    assign evt.armed     = armDly[1];

    // Interface state: load defaults once, then idle or busy by strobe activity.
    always_comb begin
        next_state = state;
        unique case (state)
            ST_LOAD: begin
                next_state = ST_IDLE;
            end
            ST_IDLE: begin
                if (wrOk || rdOk) begin
                    next_state = ST_BUSY;
                end
            end
            ST_BUSY: begin
                if (!clr_n || !(wrOk || rdOk)) begin
                    next_state = ST_IDLE;
                end
            end
        endcase
    end

    // State and standby flag; the power-on clear holds the interface in loading.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state   <= ST_LOAD;
            standby <= 1'b0;
        end else begin
            state   <= next_state;
            standby <= next_state == ST_IDLE;
        end
    end

    // Pins show the loaded latches and pullups one edge after the load, and the sample
    // one edge later, so arming waits two edges to keep a false change out of the flags.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            armDly <= 2'h0;
        end else begin
            armDly <= {armDly[0], (state != ST_LOAD)};
        end
    end

    // Output latches and open-drain enables clear to zero whenever the power-on clear acts.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            upperOut <= RST_UPPER;
            lowerOut <= RST_LOPP;
            odLatch  <= RST_OD;
            odOe     <= 4'h0;
        end else begin
            upperOut <= next_upper;
            lowerOut <= next_loPp;
            odLatch  <= next_od;
            odOe     <= ~next_od;
        end
    end

    // Pin sample, read data, pullups and the open-drain request pin.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pinSample <= 4'h0;
            busRdData <= RST_RDATA;
            pullupEn  <= 4'h0;
            odOut     <= 4'h0;
            intReqOut <= 1'b0;
            intReqOe  <= 1'b0;
        end else begin
            pinSample <= odIn;
            busRdData <= next_rdData;
            pullupEn  <= pullupSel;
            odOut     <= 4'h0;
            intReqOut <= 1'b0;
            intReqOe  <= evt.intReq;
        end
    end

    // Sequences for the standby behaviour and the default load.
    sequence s_taken;
        (wrOk || rdOk);
    endsequence

    sequence s_quiet;
        !(wrOk || rdOk) && state == ST_BUSY;
    endsequence

    sequence s_load;
        state == ST_LOAD && arst_n;
    endsequence

    sequence s_two_quiet;
        !(wrOk || rdOk) ##1 !(wrOk || rdOk);
    endsequence

    a_standby_leave: assert property (@(posedge core_clk) disable iff (!arst_n)
        s_taken |=> !standby)
        else $error("Standby held while a strobe was taken.");

    a_standby_enter: assert property (@(posedge core_clk) disable iff (!arst_n)
        s_quiet |=> standby)
        else $error("Idle interface did not enter standby.");

    a_read_window: assert property (@(posedge core_clk) disable iff (!arst_n)
        !$past(rdOk) && state != ST_LOAD |-> busRdData == RST_RDATA)
        else $error("Read data outside its cycle.");

    a_read_pins: assert property (@(posedge core_clk) disable iff (!arst_n)
        (rdOk && hitLower) |=> busRdData[LOW_OD_LSB +: IOX_NUM_OD] == $past(pinSample))
        else $error("Lower read did not return pin levels.");

    a_upper_write: assert property (@(posedge core_clk) disable iff (!arst_n)
        wrUpper |=> (upperOut == $past(busWrData)) && $stable(odLatch))
        else $error("Upper group write misrouted.");

    a_clear_blocks: assert property (@(posedge core_clk) disable iff (!arst_n)
        (!clr_n && state != ST_LOAD) |=> $stable(upperOut) && $stable(lowerOut)
                                         && $stable(odLatch) && standby)
        else $error("Transfer taken during external clear.");

    a_default_load: assert property (@(posedge core_clk) disable iff (!arst_n)
        s_load |=> (odLatch == $past(defOd)) && (upperOut == $past(defUpper)))
        else $error("Defaults not loaded from the selects.");

    a_int_pin: assert property (@(posedge core_clk) disable iff (!arst_n)
        (evt.intReq != intReqOe) |=> (intReqOe == $past(evt.intReq)) && !intReqOut)
        else $error("Interrupt pin does not follow its latch.");

    a_pullup_pairs: assert property (@(posedge core_clk) disable iff (!arst_n)
        arst_n |=> pullupEn == {{2{$past(addrSelHi) != SEL_GND}},
                                {2{$past(addrSelLo) != SEL_GND}}})
        else $error("Pullup pairs do not follow the selects.");

    // Further checks on the load, the lower group, standby, unmapped writes, readback and the external clear.
    a_lower_default: assert property (@(posedge core_clk) disable iff (!arst_n)
        s_load |=> (lowerOut == $past(defLoPp)) && (odOe == ~$past(defOd)))
        else $error("Lower group defaults not loaded from the selects.");

    a_pullup_split: assert property (@(posedge core_clk) disable iff (!arst_n)
        s_load |=> (odOe & pullupEn) == 4'h0)
        else $error("Port with pullup left reset pulled low.");

    a_standby_quiet: assert property (@(posedge core_clk) disable iff (!arst_n)
        s_two_quiet |=> standby)
        else $error("Standby missing after two quiet cycles.");

    a_lower_write: assert property (@(posedge core_clk) disable iff (!arst_n)
        wrLower |=> (lowerOut == {$past(busWrData[LOW_PPB_LSB +: 2]),
                                  $past(busWrData[LOW_PPA_LSB +: 2])}) && $stable(upperOut))
        else $error("Lower group write misrouted.");

    a_od_write: assert property (@(posedge core_clk) disable iff (!arst_n)
        wrLower |=> odOe == ~$past(busWrData[LOW_OD_LSB +: IOX_NUM_OD]))
        else $error("Open-drain enables do not follow the written latches.");

    a_unmapped_write: assert property (@(posedge core_clk) disable iff (!arst_n)
        (wrOk && !hitAny) |=> $stable(upperOut) && $stable(lowerOut) && $stable(odLatch))
        else $error("Write to an unmapped address changed a latch.");

    a_upper_read: assert property (@(posedge core_clk) disable iff (!arst_n)
        (rdOk && hitUpper) |=> busRdData == $past(upperOut))
        else $error("Upper read did not return the upper latches.");

    a_flag_read: assert property (@(posedge core_clk) disable iff (!arst_n)
        (rdOk && hitFlags) |=> busRdData == {4'h0, $past(evt.changeFlags)})
        else $error("Flag read did not return the flags before clearing.");

    a_clear_int_kept: assert property (@(posedge core_clk) disable iff (!arst_n)
        (!clr_n && evt.intReq) |=> evt.intReq)
        else $error("External clear dropped the interrupt request.");

    a_clear_flags_kept: assert property (@(posedge core_clk) disable iff (!arst_n)
        !clr_n |=> (evt.changeFlags & $past(evt.changeFlags)) == $past(evt.changeFlags))
        else $error("External clear dropped a change flag.");
endmodule : iox_port_core

/* core/iox_sel_decode.sv */
// Decoder from the two address-select codes to defaults and pullup enables.
`timescale 1ns/100ps
module iox_sel_decode
    import iox_pkg::*;
(
    input  wire logic [1:0] addrSelLo,
    input  wire logic [1:0] addrSelHi,
    output logic      [7:0] defUpper,
    output logic      [3:0] defLoPp,
    output logic      [3:0] defOd,
    output logic      [3:0] pullupSel
);
    logic loHigh;
    logic hiHigh;

    // Each select input reads high for supply, clock or data ties, low only for ground.
    assign loHigh    = iox_sel_high(addrSelLo);
    assign hiHigh    = iox_sel_high(addrSelHi);

    // Pullups in pairs: low select drives the first two ports, high select the last two.
    assign pullupSel = {hiHigh, hiHigh, loHigh, loHigh};

    // Open-drain latches start high where pullups are on, low where they are off.
    assign defOd     = pullupSel;

    // Push-pull defaults in pairs: O0,O1 follow the low select, O6,O7 the high one.
    assign defLoPp   = {hiHigh, hiHigh, loHigh, loHigh};
    assign defUpper  = {{4{hiHigh}}, {4{loHigh}}};
endmodule : iox_sel_decode
